// ### serial_rom_pkg.sv
package serial_rom_pkg;
  // register byte offsets
  localparam logic [11:0] CMD_OFF   = 12'h0b0;
  localparam logic [11:0] DATA_OFF  = 12'h0b4;
  localparam logic [11:0] ISTAT_OFF = 12'h0b8;
  localparam logic [11:0] IMASK_OFF = 12'h0bc;
  // command register layout
  localparam int BUSY_BIT   = 31;
  localparam int CMD_MSB    = 30;
  localparam int CMD_LSB    = 28;
  localparam int TMO_BIT    = 9;
  localparam int LOADED_BIT = 8;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // interrupt status layout
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TMO_BIT  = 1;
  localparam int IRQ_W        = 2;
  // command field codes
  localparam logic [2:0] CMD_READ   = 3'h0;
  localparam logic [2:0] CMD_ERASE_WRITE_DISABLE_CMD   = 3'h1;
  localparam logic [2:0] CMD_ERASE_WRITE_ENABLE_CMD   = 3'h2;
  localparam logic [2:0] CMD_WRITE  = 3'h3;
  localparam logic [2:0] CMD_WRITE_ALL_CMD   = 3'h4;
  localparam logic [2:0] CMD_ERASE  = 3'h5;
  localparam logic [2:0] CMD_ERASE_ALL_CMD   = 3'h6;
  localparam logic [2:0] CMD_RELOAD = 3'h7;
  // serial opcodes and extended-address prefixes
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_ERASE_WRITE_DISABLE_CMD = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL_CMD = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] EXT_ERASE_WRITE_ENABLE_CMD = 2'h3;
  // frame lengths in bits
  localparam logic [4:0] HDR_BITS  = 5'd11;
  localparam logic [4:0] BYTE_BITS = 5'd8;
  localparam int FRAME_W = 19;
  // mac reload image
  localparam logic [7:0] MAC_SIG   = 8'ha5;
  localparam logic [2:0] MAC_BYTES = 3'd6;
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int TIMEOUT_MS   = 30;
  localparam int TIMEOUT_CYC  = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int SCLK_HALF_NS = 500;
  localparam int SCLK_DIV     = (SCLK_HALF_NS * CLK_MHZ) / 1000;
endpackage

// ### tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 50
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output var  logic tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;

  // held at zero when idle so every frame starts in phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output var  logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// ### serial_rom_controller.sv
// Notes on behaviour
// - no ready from memory within 30 ms abandons operation, back to idle
// - timeout sets command bit 9, marking last operation failed
// - data pin high with no memory: no timeout, busy clears at end
// - pin low, no memory: only write, write-all, erase, erase-all time out
// - bit 8 set when valid memory found and mac load completes
// - byte address taken from command bits 7-0, read/write, resets 00h
// - data register low byte holds write byte or read result
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module serial_rom_controller #(
  parameter int TIMEOUT_CYCLES = serial_rom_pkg::TIMEOUT_CYC,
  parameter int SCLK_DIVIDE    = serial_rom_pkg::SCLK_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  output var  logic        rom_cs,
  output var  logic        rom_sclk,
  input  wire logic        serial_rom_data_pin_i,
  output var  logic        serial_rom_data_pin_o,
  output var  logic        serial_rom_data_pin_oe,
  output var  logic [47:0] mac_addr,
  output var  logic        mac_addr_valid
);
  import serial_rom_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);
  // cycles the synchroniser needs before the polled pin is trusted
  localparam logic [TW-1:0] SETTLE   = TW'(5);

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_SHIFT, ST_END, ST_GAP, ST_POLL, ST_NEXT
  } state_t;

  state_t              state_r;
  logic [2:0]          cmd_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [DATA_W-1:0]   data_r;
  logic                busy_r;
  logic                tmo_flag_r;
  logic                loaded_r;
  logic                reload_pend_r;
  logic [FRAME_W-1:0]  tx_r;
  logic [4:0]          nbits_r;
  logic [4:0]          rd_len_r;
  logic [DATA_W-1:0]   rx_r;
  logic                phase_r;
  logic [TW-1:0]       tmo_cnt_r;
  logic [2:0]          rl_idx_r;
  logic                fin_r;
  logic                fin_tmo_r;
  logic [IRQ_W-1:0]    istat_r;
  logic [IRQ_W-1:0]    imask_r;
  logic                din_s;
  logic                tick;

  // ---------------------------------------------------------------
  // apb decode; one access-phase cycle per transfer, no wait states
  wire setup_ph  = psel & ~penable & ~pready;
  wire access_ok = psel & penable & pready;
  wire hit_cmd   = (paddr == CMD_OFF);
  wire hit_data  = (paddr == DATA_OFF);
  wire hit_istat = (paddr == ISTAT_OFF);
  wire hit_imask = (paddr == IMASK_OFF);
  wire hit_any   = hit_cmd | hit_data | hit_istat | hit_imask;
  wire wr_cmd    = access_ok & pwrite & hit_cmd;
  wire wr_data   = access_ok & pwrite & hit_data;
  wire wr_istat  = access_ok & pwrite & hit_istat;
  wire wr_imask  = access_ok & pwrite & hit_imask;

  wire start_cmd = wr_cmd & pwdata[BUSY_BIT] & ~busy_r;

  // readback words; reserved bits read as zero
  wire [31:0] cmd_word = {busy_r, cmd_r, 18'h0, tmo_flag_r, loaded_r,
                          addr_r};
  wire [31:0] data_word  = {24'h0, data_r};
  wire [31:0] istat_word = {30'h0, istat_r};
  wire [31:0] imask_word = {30'h0, imask_r};
  wire [31:0] rd_word = hit_cmd   ? cmd_word   :
                        hit_data  ? data_word  :
                        hit_istat ? istat_word :
                        hit_imask ? imask_word : 32'h0;

  // answer is registered so outputs come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= setup_ph ? rd_word : 32'h0;
      pslverr <= setup_ph & ~hit_any;
    end
  end

  // ---------------------------------------------------------------
  // command classes
  wire is_reload = (cmd_r == CMD_RELOAD);
  wire is_read   = (cmd_r == CMD_READ) | is_reload;
  wire is_wdata  = (cmd_r == CMD_WRITE) | (cmd_r == CMD_WRITE_ALL_CMD);
  // only these wait for the memory ready
  wire is_prog   = is_wdata | (cmd_r == CMD_ERASE) | (cmd_r == CMD_ERASE_ALL_CMD);

  // serial opcode and address field for the current command
  logic [1:0]        wire_op;
  logic [ADDR_W-1:0] wire_addr;
  always_comb begin
    wire_op   = OP_EXT;
    wire_addr = {EXT_ERASE_WRITE_DISABLE_CMD, 6'h0};
    case (cmd_r)
      CMD_READ:   begin wire_op = OP_READ;  wire_addr = addr_r; end
      // enable sequence opens the memory for programming
      CMD_ERASE_WRITE_ENABLE_CMD:   begin wire_addr = {EXT_ERASE_WRITE_ENABLE_CMD, 6'h0}; end
      CMD_ERASE_WRITE_DISABLE_CMD:   begin wire_addr = {EXT_ERASE_WRITE_DISABLE_CMD, 6'h0}; end
      CMD_WRITE:  begin wire_op = OP_WRITE; wire_addr = addr_r; end
      CMD_WRITE_ALL_CMD:   begin wire_addr = {EXT_WRITE_ALL_CMD, 6'h0}; end
      CMD_ERASE:  begin wire_op = OP_ERASE; wire_addr = addr_r; end
      CMD_ERASE_ALL_CMD:   begin wire_addr = {EXT_ERASE_ALL_CMD, 6'h0}; end
      CMD_RELOAD: begin
        wire_op   = OP_READ;
        wire_addr = {5'h0, rl_idx_r};
      end
      default:    begin wire_op = OP_EXT; end
    endcase
  end

  wire [FRAME_W-1:0] tx_word = {1'b1, wire_op, wire_addr, data_r};
  wire [4:0] rd_len  = is_read ? BYTE_BITS : 5'd0;
  wire [4:0] frame_n = HDR_BITS + rd_len + (is_wdata ? BYTE_BITS : 5'd0);
  wire       last_bit = phase_r & (nbits_r == 5'd1);
  wire       drive_bit = (nbits_r > rd_len_r);
  wire [DATA_W-1:0] rx_new = {rx_r[DATA_W-2:0], din_s};
  wire       tmo_hit = (tmo_cnt_r == TMO_LAST);
  // stale pin level from the gap is ignored until the sync has caught up
  wire       poll_rdy = din_s & (tmo_cnt_r >= SETTLE);
  wire       tmo_now  = (state_r == ST_POLL) & ~poll_rdy & tmo_hit;
  wire       rl_bad  = (rl_idx_r == 3'd0) & (rx_r != MAC_SIG);
  wire       rl_last = (rl_idx_r == MAC_BYTES);
  wire       run_div = (state_r != ST_IDLE) & (state_r != ST_POLL);

  tick_divider #(.DIV(SCLK_DIVIDE)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_div),
    .tick    (tick)
  );

  pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (serial_rom_data_pin_i),
    .level   (din_s)
  );

  // ---------------------------------------------------------------
  // sequencer: half a serial clock per tick, sample on the rising half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= ST_IDLE;
      cmd_r         <= CMD_READ;
      busy_r        <= 1'b0;
      reload_pend_r <= 1'b1;
      tx_r          <= '0;
      nbits_r       <= 5'd0;
      rd_len_r      <= 5'd0;
      rx_r          <= '0;
      phase_r       <= 1'b0;
      tmo_cnt_r     <= '0;
      rl_idx_r      <= 3'd0;
      fin_r         <= 1'b0;
      fin_tmo_r     <= 1'b0;
      rom_cs        <= 1'b0;
      rom_sclk      <= 1'b0;
      serial_rom_data_pin_o  <= 1'b0;
      serial_rom_data_pin_oe <= 1'b0;
    end else begin
      fin_r     <= 1'b0;
      fin_tmo_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // power-up reload runs before any software command
          if (reload_pend_r) begin
            reload_pend_r <= 1'b0;
            cmd_r    <= CMD_RELOAD;
            busy_r   <= 1'b1;
            rl_idx_r <= 3'd0;
            state_r  <= ST_LOAD;
          end else if (start_cmd) begin
            cmd_r    <= pwdata[CMD_MSB:CMD_LSB];
            busy_r   <= 1'b1;
            rl_idx_r <= 3'd0;
            state_r  <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // one tick with select low separates frames
          if (tick) begin
            tx_r     <= tx_word;
            nbits_r  <= frame_n;
            rd_len_r <= rd_len;
            phase_r  <= 1'b0;
            rom_cs   <= 1'b1;
            state_r  <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick && !phase_r) begin
            rom_sclk <= 1'b0;
            serial_rom_data_pin_o  <= drive_bit & tx_r[FRAME_W-1];
            serial_rom_data_pin_oe <= drive_bit;
            phase_r  <= 1'b1;
          end else if (tick) begin
            rom_sclk <= 1'b1;
            phase_r  <= 1'b0;
            tx_r     <= {tx_r[FRAME_W-2:0], 1'b0};
            nbits_r  <= nbits_r - 5'd1;
            if (!drive_bit) begin
              rx_r <= rx_new;
            end
          end
          // select stays up through the last high half so that bit lands
          if (tick && last_bit) begin
            state_r <= ST_END;
          end
        end
        ST_END: begin
          // select and clock fall together; clock never idles high
          if (tick) begin
            rom_cs   <= 1'b0;
            rom_sclk <= 1'b0;
            serial_rom_data_pin_oe <= 1'b0;
            if (is_prog) begin
              state_r <= ST_GAP;
            end else if (is_reload) begin
              state_r <= ST_NEXT;
            end else begin
              busy_r  <= 1'b0;
              fin_r   <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            rom_sclk  <= 1'b0;
            rom_cs    <= 1'b1;
            tmo_cnt_r <= '0;
            state_r   <= ST_POLL;
          end
        end
        ST_POLL: begin
          // a high pin reads as ready once settled
          if (poll_rdy) begin
            rom_cs  <= 1'b0;
            busy_r  <= 1'b0;
            fin_r   <= 1'b1;
            state_r <= ST_IDLE;
          // give up after the timeout window
          end else if (tmo_hit) begin
            rom_cs    <= 1'b0;
            busy_r    <= 1'b0;
            fin_r     <= 1'b1;
            fin_tmo_r <= 1'b1;
            state_r   <= ST_IDLE;
          end else begin
            tmo_cnt_r <= tmo_cnt_r + 1'b1;
          end
        end
        ST_NEXT: begin
          // missing signature ends the reload without loading
          if (rl_bad || rl_last) begin
            busy_r  <= 1'b0;
            fin_r   <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            rl_idx_r <= rl_idx_r + 3'd1;
            state_r  <= ST_LOAD;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // software-visible fields and mac image
  wire rl_store = (state_r == ST_NEXT) & ~rl_bad & (rl_idx_r != 3'd0);
  wire rl_done  = (state_r == ST_NEXT) & ~rl_bad & rl_last;
  wire rd_done  = (state_r == ST_END) & tick & (cmd_r == CMD_READ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r     <= ADDR_RST;
      data_r     <= DATA_RST;
      tmo_flag_r <= 1'b0;
      loaded_r   <= 1'b0;
      mac_addr   <= 48'h0;
    end else begin
      if (wr_cmd && !busy_r) begin
        addr_r <= pwdata[ADDR_W-1:0];
      end
      // result byte lands in the data register
      if (rd_done) begin
        data_r <= rx_r;
      end else if (wr_data && !busy_r) begin
        data_r <= pwdata[DATA_W-1:0];
      end
      // flag kept until the next command starts
      if (tmo_now) begin
        tmo_flag_r <= 1'b1;
      end else if (start_cmd) begin
        tmo_flag_r <= 1'b0;
      end
      // loaded only on a complete signed image
      if (rl_done) begin
        loaded_r <= 1'b1;
      end else if ((state_r == ST_NEXT) && rl_bad) begin
        loaded_r <= 1'b0;
      end
      if (rl_store) begin
        mac_addr <= {rx_r, mac_addr[47:8]};
      end
    end
  end

  assign mac_addr_valid = loaded_r;

  // ---------------------------------------------------------------
  // sticky events, write one to clear; a new event beats the clear
  wire [IRQ_W-1:0] ev_set = {fin_tmo_r, fin_r};
  wire [IRQ_W-1:0] ev_clr = wr_istat ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq     <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~ev_clr) | ev_set;
      if (wr_imask) begin
        imask_r <= pwdata[IRQ_W-1:0];
      end
      irq <= |(istat_r & imask_r);
    end
  end
endmodule
`default_nettype wire

// ### serial_rom_controller_properties.sv
`timescale 1ns/100ps
`default_nettype none
module serial_rom_checker
  import serial_rom_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 200,
  parameter int SCLK_DIVIDE    = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rom_cs,
  input wire logic        rom_sclk,
  input wire logic        mac_addr_valid
);
  // a write frame plus the longest ready poll
  localparam int CS_LIMIT = TIMEOUT_CYCLES + 40 * SCLK_DIVIDE + 8;
  logic [31:0] cs_cnt_r, hi_cnt_r;
  logic [31:0] cs_cnt_nxt, hi_cnt_nxt;
  wire         mapped;
  // address decode and run-length counters
  assign mapped = paddr == CMD_OFF || paddr == DATA_OFF ||
                  paddr == ISTAT_OFF || paddr == IMASK_OFF;
  assign cs_cnt_nxt = rom_cs ? cs_cnt_r + 32'h1 : 32'h0;
  assign hi_cnt_nxt = rom_sclk ? hi_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_cnt_r <= 32'h0;
      hi_cnt_r <= 32'h0;
    end else begin
      cs_cnt_r <= cs_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence cmd_read_s;
    pready && !pwrite && paddr == CMD_OFF;
  endsequence
  ready_next_a: assert property (setup_s |=> pready)
    else $error("no answer in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  slverr_map_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not follow decode");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  loaded_mirror_a: assert property (cmd_read_s |->
    prdata[LOADED_BIT] == mac_addr_valid ||
    prdata[LOADED_BIT] == $past(mac_addr_valid))
    else $error("loaded flag and valid output differ");
  sclk_frame_a: assert property (rom_sclk |-> rom_cs)
    else $error("serial clock outside a frame");
  sclk_width_a: assert property ($fell(rom_sclk) |-> hi_cnt_r == SCLK_DIVIDE)
    else $error("serial clock high time wrong");
  frame_bound_a: assert property (cs_cnt_r <= CS_LIMIT)
    else $error("select held past the timeout");
endmodule
bind serial_rom_controller serial_rom_checker #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .SCLK_DIVIDE   (SCLK_DIVIDE)
) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rom_cs(rom_cs), .rom_sclk(rom_sclk),
  .mac_addr_valid(mac_addr_valid)
);
`default_nettype wire

// ### serial_rom_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_rom_model #(
  parameter int WR_DELAY = 20
) (
  input  wire logic pclk,
  input  wire logic present,
  input  wire logic rom_cs,
  input  wire logic rom_sclk,
  input  wire logic pin,
  output var  logic drv_oe,
  output var  logic drv_val
);
  import serial_rom_pkg::*;
  logic [7:0]  mem [256];
  logic [18:0] sr;
  logic [7:0]  rbyte;
  logic        wen, reading, polling, accepted;
  int          nbit, rk, wait_cnt;
  initial begin
    wen = 1'b0;
    {drv_oe, drv_val, reading, polling, accepted} = 5'h0;
    {nbit, rk, wait_cnt} = '0;
    sr = 19'h0;
    for (int i = 0; i < 256; i++) mem[i] = 8'hff;
    mem[0] = MAC_SIG;
    for (int i = 1; i < 7; i++) mem[i] = 8'h10 + 8'(i);
  end
  // bits shift in on the rising serial clock
  always @(posedge rom_sclk) begin
    if (present && rom_cs && !polling) begin
      sr = {sr[17:0], pin};
      nbit++;
      if (nbit == 11 && sr[9:8] == OP_READ) begin
        reading = 1'b1;
        rbyte = mem[sr[7:0]];
        rk = 0;
      end
    end
  end
  // read bits move on the falling edge, clear of the sample point
  always @(negedge rom_sclk) begin
    if (reading && rk < 8) begin
      drv_oe = 1'b1;
      drv_val = rbyte[7 - rk];
      rk++;
    end
  end
  always @(posedge rom_cs) begin
    nbit = 0;
    drv_oe = polling;
    drv_val = 1'b0;
  end
  always @(negedge rom_cs) begin
    drv_oe = 1'b0;
    reading = 1'b0;
    if (polling) polling = 1'b0;
    else if (present && nbit >= 11) frame_end();
  end
  task automatic frame_end();
    logic [1:0] op;
    logic [7:0] a;
    logic [1:0] ext;
    op = (nbit == 19) ? sr[17:16] : sr[9:8];
    a = (nbit == 19) ? sr[15:8] : sr[7:0];
    ext = a[7:6];
    if (op == OP_READ) return;
    polling = !(op == OP_EXT && (ext == EXT_ERASE_WRITE_ENABLE_CMD || ext == EXT_ERASE_WRITE_DISABLE_CMD));
    accepted = wen;
    wait_cnt = WR_DELAY;
    // erase and write refused until enabled
    if (wen && op == OP_WRITE) mem[a] = sr[7:0];
    if (wen && op == OP_ERASE) mem[a] = 8'hff;
    for (int i = 0; i < 256; i++) begin
      if (wen && op == OP_EXT && ext == EXT_WRITE_ALL_CMD) mem[i] = sr[7:0];
      if (wen && op == OP_EXT && ext == EXT_ERASE_ALL_CMD) mem[i] = 8'hff;
    end
    if (op == OP_EXT && ext == EXT_ERASE_WRITE_ENABLE_CMD) wen = 1'b1;
    if (op == OP_EXT && ext == EXT_ERASE_WRITE_DISABLE_CMD) wen = 1'b0;
  endtask
  // refused writes keep ready low forever, so the host times out
  always @(posedge pclk) begin
    if (polling && rom_cs) begin
      if (wait_cnt > 0) wait_cnt--;
      drv_val <= accepted && wait_cnt == 0;
    end
  end
endmodule
`default_nettype wire

// ### serial_rom_controller_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module serial_rom_controller_tb_top;
  import serial_rom_pkg::*;
  localparam int TMO = 200;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pull_lvl = 1'b1, rom_fit = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, rom_cs, rom_sclk, pin_o, pin_oe, err;
  logic        rom_oe, rom_v, mac_addr_valid;
  logic [47:0] mac_addr;
  wire         pin;
  int          n_mismatch = 0, cmp_count = 0;
  time         t0;
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
  always #5 pclk = ~pclk;
  // board pull decides the pin while nobody drives it
  assign pin = pin_oe ? pin_o : (rom_oe ? rom_v : pull_lvl);
  serial_rom_controller #(.TIMEOUT_CYCLES(TMO), .SCLK_DIVIDE(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .rom_cs(rom_cs),
    .rom_sclk(rom_sclk), .serial_rom_data_pin_i(pin),
    .serial_rom_data_pin_o(pin_o), .serial_rom_data_pin_oe(pin_oe),
    .mac_addr(mac_addr), .mac_addr_valid(mac_addr_valid));
  serial_rom_model rom (.pclk(pclk), .present(rom_fit), .rom_cs(rom_cs),
    .rom_sclk(rom_sclk), .pin(pin), .drv_oe(rom_oe), .drv_val(rom_v));
  // one apb transfer, request held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      xfer(1'b0, CMD_OFF, 32'h0);
      k++;
    end while (rd[BUSY_BIT] !== 1'b0 && k < 3000);
    `CHK(rd[BUSY_BIT], 1'b0)
  endtask
  task automatic run(input logic [2:0] c, input logic [7:0] a);
    xfer(1'b1, CMD_OFF, {1'b1, c, 20'h0, a});
    wait_idle();
  endtask
  task automatic rdback(input logic [7:0] a, input logic [7:0] exp);
    run(CMD_READ, a);
    xfer(1'b0, DATA_OFF, 32'h0);
    `CHK(rd, {24'h0, exp})
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, well past the longest sequence
  initial begin
    #(80000 * 10);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and refused places while power-up load runs
    xfer(1'b0, DATA_OFF, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, IMASK_OFF, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, 12'h0c0, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    xfer(1'b0, CMD_OFF, 32'h0);
    `CHK({rd[BUSY_BIT], rd[7:0]}, 9'h100)
    xfer(1'b1, CMD_OFF, {1'b1, CMD_WRITE, 20'h0, 8'h55});
    wait_idle();
    `CHK(rd[7:0], 8'h00)
    `CHK({rd[LOADED_BIT], mac_addr}, {1'b1, 48'h161514131211})
    // write before enable: refused, so it times out
    xfer(1'b1, DATA_OFF, 32'h3c);
    t0 = $time;
    run(CMD_WRITE, 8'h20);
    `CHK({rd[TMO_BIT], rd[7:0]}, 9'h120)
    `CHK(($time - t0) > TMO * 10, 1'b1)
    `CHK(irq, 1'b0)
    xfer(1'b1, IMASK_OFF, 32'h2);
    xfer(1'b0, ISTAT_OFF, 32'h0);
    `CHK({irq, rd[IRQ_TMO_BIT]}, 2'b11)
    xfer(1'b1, ISTAT_OFF, 32'h3);
    xfer(1'b1, IMASK_OFF, 32'h1);
    `CHK(irq, 1'b0)
    // enable, then every write and erase kind with read-back
    run(CMD_ERASE_WRITE_ENABLE_CMD, 8'h00);
    `CHK(irq, 1'b1)
    xfer(1'b1, ISTAT_OFF, 32'h3);
    run(CMD_WRITE, 8'h20);
    `CHK(rd[TMO_BIT], 1'b0)
    rdback(8'h20, 8'h3c);
    run(CMD_ERASE, 8'h20);
    rdback(8'h20, 8'hff);
    xfer(1'b1, DATA_OFF, 32'h5a);
    run(CMD_WRITE_ALL_CMD, 8'h00);
    rdback(8'h07, 8'h5a);
    run(CMD_ERASE_ALL_CMD, 8'h00);
    rdback(8'h07, 8'hff);
    run(CMD_ERASE_WRITE_DISABLE_CMD, 8'h00);
    run(CMD_WRITE, 8'h07);
    `CHK(rd[TMO_BIT], 1'b1)
    run(CMD_RELOAD, 8'h00);
    `CHK({rd[LOADED_BIT], mac_addr_valid}, 2'b00)
    // no memory fitted, pin pulled high and then low
    rom_fit <= 1'b0;
    for (int p = 1; p >= 0; p--) begin
      pull_lvl <= p[0];
      for (int c = 0; c < 8; c++) begin
        run(c[2:0], 8'h00);
        `CHK(rd[TMO_BIT], p == 0 && c >= 3 && c <= 6)
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
